// ===== sde_pkg.sv
// Shared constants and carrier types of the message digest engine.
package sde_pkg;

  localparam int unsigned WORD_W      = 32;
  localparam int unsigned BLOCK_WORDS = 16;
  localparam logic [6:0]  ROUND_LAST  = 7'h4F;
  localparam logic [4:0]  REQ_WORDS   = 5'h10;
  localparam logic [3:0]  LEN_HI_IDX  = 4'hE;
  localparam logic [3:0]  LEN_LO_IDX  = 4'hF;
  localparam logic [3:0]  LEN_ROOM_IDX = 4'hD;
  localparam logic [31:0] PAD_WORD    = 32'h8000_0000;
  localparam logic [1:0]  BYTES_ALL   = 2'h3;
  localparam logic [60:0] BYTES_WORD  = 61'h4;

  localparam logic [31:0] IV0 = 32'h6745_2301;
  localparam logic [31:0] IV1 = 32'hEFCD_AB89;
  localparam logic [31:0] IV2 = 32'h98BA_DCFE;
  localparam logic [31:0] IV3 = 32'h1032_5476;
  localparam logic [31:0] IV4 = 32'hC3D2_E1F0;

  localparam logic [31:0] K0 = 32'h5A82_7999;
  localparam logic [31:0] K1 = 32'h6ED9_EBA1;
  localparam logic [31:0] K2 = 32'h8F1B_BCDC;
  localparam logic [31:0] K3 = 32'hCA62_C1D6;
  localparam logic [6:0]  ROUND_Q1 = 7'h14;
  localparam logic [6:0]  ROUND_Q2 = 7'h28;
  localparam logic [6:0]  ROUND_Q3 = 7'h3C;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
    logic [1:0]  bytes;
  } sde_word_t;

  typedef enum {
    SDE_IDLE,
    SDE_LOAD,
    SDE_PAD,
    SDE_COMPUTE,
    SDE_FINISH
  } sde_phase_t;

  typedef struct packed {
    sde_phase_t         phase;
    logic [6:0]         round;
    logic [4:0][31:0]   work;
    logic [4:0][31:0]   hash;
    logic [15:0][31:0]  sched;
    logic [60:0]        nbytes;
    logic               msg_done;
    logic               pad_done;
    logic               len_room;
    logic               len_done;
    logic [4:0]         in_cnt;
    logic               in_last;
    logic               req;
    logic               valid;
    logic [4:0][31:0]   digest;
  } sde_state_t;

endpackage

// ===== sde_word_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps

module sde_word_buffer #(
  parameter int unsigned WIDTH = 35
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic                  head;
    logic [1:0]            count;
  } sde_buf_state_t;

  sde_buf_state_t cur_ff;
  sde_buf_state_t nxt_buf;
  logic           push;
  logic           pop;
  logic           tail;

  assign in_ready  = (cur_ff.count != 2'h2);
  assign out_valid = (cur_ff.count != 2'h0);
  assign out_data  = cur_ff.slot[cur_ff.head];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign tail      = cur_ff.head ^ cur_ff.count[0];

  always_comb
  begin
    nxt_buf = cur_ff;
    if (push)
    begin
      nxt_buf.slot[tail] = in_data;
    end
    if (pop)
    begin
      nxt_buf.head = ~cur_ff.head;
    end
    nxt_buf.count = cur_ff.count + {1'b0, push} - {1'b0, pop};
    if (flush)
    begin
      nxt_buf.count = 2'h0;
      nxt_buf.head  = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_buf;
    end
  end

endmodule // sde_word_buffer

// ===== sde_sha1_engine.sv
`timescale 1ns/1ps

module sde_sha1_engine (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        enable,
  input  wire logic        msg_start,
  input  wire logic [31:0] din,
  input  wire logic        word_accept,
  input  wire logic [1:0]  last_bytes,
  input  wire logic        last_word,
  output logic             word_request,
  output logic             digest_valid,
  output logic [31:0]      digest_word_first,
  output logic [31:0]      digest_word_second,
  output logic [31:0]      digest_word_third,
  output logic [31:0]      digest_word_fourth,
  output logic [31:0]      digest_word_fifth
);

  // The synchronised reset still asserts at once, so outputs clear
  // without waiting for a clock edge.
  logic [1:0]          rst_sync_ff;
  logic                rst_n;
  sde_pkg::sde_state_t cur_ff;
  sde_pkg::sde_state_t nxt_st;
  sde_pkg::sde_word_t  in_word;
  sde_pkg::sde_word_t  buf_word;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic                buf_pop;
  logic                accept;
  logic                flush;

  // Release passes two flops so that no register leaves reset alone.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync_ff <= 2'h0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  function automatic logic [31:0] rol(input logic [31:0] v,
                                     input int unsigned n);
    rol = (v << n) | (v >> (32 - n));
  endfunction

  // One SHA-1 round; work[4] is a and work[0] is e.
  function automatic logic [4:0][31:0] sha_round(
    input logic [6:0]       t,
    input logic [4:0][31:0] s,
    input logic [31:0]      w
  );
    logic [31:0] f;
    logic [31:0] k;
    logic [31:0] tmp;
    if (t < sde_pkg::ROUND_Q1)
    begin
      f = (s[3] & s[2]) | (~s[3] & s[1]);
      k = sde_pkg::K0;
    end
    else if (t < sde_pkg::ROUND_Q2)
    begin
      f = s[3] ^ s[2] ^ s[1];
      k = sde_pkg::K1;
    end
    else if (t < sde_pkg::ROUND_Q3)
    begin
      f = (s[3] & s[2]) | (s[3] & s[1]) | (s[2] & s[1]);
      k = sde_pkg::K2;
    end
    else
    begin
      f = s[3] ^ s[2] ^ s[1];
      k = sde_pkg::K3;
    end
    tmp = rol(s[4], 5) + f + s[0] + k + w;
    sha_round = {tmp, s[4], rol(s[3], 30), s[2], s[1]};
  endfunction

  // Keeps the valid top bytes, then places the pad byte just below them unless all four bytes are valid.
  function automatic logic [31:0] pad_last(input logic [31:0] d,
                                           input logic [1:0]  b);
    case (b)
      2'h0:    pad_last = {d[31:24], 24'h80_0000};
      2'h1:    pad_last = {d[31:16], 16'h8000};
      2'h2:    pad_last = {d[31:8], 8'h80};
      default: pad_last = d;
    endcase
  endfunction

  // Both length words need the last two slots of a block, so the padded
  // word must sit in slot 13 or below for them to share its block.
  function automatic logic room_for_len(input logic [3:0] slot);
    room_for_len = (slot <= sde_pkg::LEN_ROOM_IDX);
  endfunction

  assign in_word.data  = din;
  assign in_word.last  = last_word;
  assign in_word.bytes = last_bytes;
  assign accept  = enable & cur_ff.req & word_accept & buf_in_ready;
  assign flush   = enable & msg_start;
  assign buf_pop = enable & (cur_ff.phase == sde_pkg::SDE_LOAD);

  // The buffer decouples the host handshake from the round logic; it
  // never fills, since loading drains one word for each one taken.
  sde_word_buffer #(
    .WIDTH ($bits(sde_pkg::sde_word_t))
  ) u_buffer (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (accept),
    .in_ready  (buf_in_ready),
    .in_data   (in_word),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_word)
  );

  always_comb
  begin
    logic [31:0]      w_in;
    logic [31:0]      w_new;
    logic [3:0]       idx;
    logic [4:0][31:0] sum;
    logic [63:0]      bit_len;
    w_in    = '0;
    w_new   = '0;
    idx     = cur_ff.round[3:0];
    sum     = '0;
    bit_len = {cur_ff.nbytes, 3'h0};
    nxt_st  = cur_ff;
    if (!enable)
    begin
      nxt_st = cur_ff;
    end
    else if (msg_start)
    begin
      nxt_st.phase    = sde_pkg::SDE_LOAD;
      nxt_st.round    = '0;
      nxt_st.hash     = {sde_pkg::IV0, sde_pkg::IV1, sde_pkg::IV2,
                         sde_pkg::IV3, sde_pkg::IV4};
      nxt_st.work     = nxt_st.hash;
      nxt_st.nbytes   = '0;
      nxt_st.msg_done = 1'b0;
      nxt_st.pad_done = 1'b0;
      nxt_st.len_room = 1'b0;
      nxt_st.len_done = 1'b0;
      nxt_st.in_cnt   = '0;
      nxt_st.in_last  = 1'b0;
      nxt_st.valid    = 1'b0;
    end
    else
    begin
      if (accept)
      begin
        nxt_st.in_cnt  = cur_ff.in_cnt + 5'h1;
        nxt_st.in_last = last_word;
      end
      case (cur_ff.phase)
        sde_pkg::SDE_LOAD:
        begin
          // Without a buffered word nothing moves, which is the stall.
          if (buf_out_valid)
          begin
            w_in = buf_word.data;
            if (buf_word.last)
            begin
              w_in = pad_last(buf_word.data, buf_word.bytes);
              nxt_st.nbytes = cur_ff.nbytes
                              + {59'h0, buf_word.bytes} + 61'h1;
              nxt_st.msg_done = 1'b1;
              nxt_st.pad_done = (buf_word.bytes != sde_pkg::BYTES_ALL);
              nxt_st.len_room = room_for_len(idx);
            end
            else
            begin
              nxt_st.nbytes = cur_ff.nbytes + sde_pkg::BYTES_WORD;
            end
            // The first sixteen rounds run on the words as they arrive.
            nxt_st.sched[idx] = w_in;
            nxt_st.work  = sha_round(cur_ff.round, cur_ff.work, w_in);
            nxt_st.round = cur_ff.round + 7'h1;
            if (idx == sde_pkg::LEN_LO_IDX)
            begin
              nxt_st.phase = sde_pkg::SDE_COMPUTE;
            end
            else if (buf_word.last)
            begin
              nxt_st.phase = sde_pkg::SDE_PAD;
            end
          end
        end
        sde_pkg::SDE_PAD:
        begin
          // Pad and length words go in one per remaining slot, so the
          // padding delay is three cycles only when the final word lands
          // in slot 12; a later slot can cost a whole extra block.
          if (!cur_ff.pad_done)
          begin
            w_in = sde_pkg::PAD_WORD;
            nxt_st.pad_done = 1'b1;
            nxt_st.len_room = room_for_len(idx);
          end
          else if (cur_ff.len_room && idx == sde_pkg::LEN_HI_IDX)
          begin
            w_in = bit_len[63:32];
          end
          else if (cur_ff.len_room && idx == sde_pkg::LEN_LO_IDX)
          begin
            w_in = bit_len[31:0];
            nxt_st.len_done = 1'b1;
          end
          nxt_st.sched[idx] = w_in;
          nxt_st.work  = sha_round(cur_ff.round, cur_ff.work, w_in);
          nxt_st.round = cur_ff.round + 7'h1;
          if (idx == sde_pkg::LEN_LO_IDX)
          begin
            nxt_st.phase = sde_pkg::SDE_COMPUTE;
          end
        end
        sde_pkg::SDE_COMPUTE:
        begin
          // The schedule is a 16-word ring indexed by the round number.
          w_new = rol(cur_ff.sched[idx + 4'hD] ^ cur_ff.sched[idx + 4'h8]
                      ^ cur_ff.sched[idx + 4'h2] ^ cur_ff.sched[idx], 1);
          nxt_st.sched[idx] = w_new;
          nxt_st.work  = sha_round(cur_ff.round, cur_ff.work, w_new);
          nxt_st.round = cur_ff.round + 7'h1;
          if (cur_ff.round == sde_pkg::ROUND_LAST)
          begin
            nxt_st.phase  = sde_pkg::SDE_FINISH;
            // The word count restarts here so that a word taken during
            // the add cycle is counted towards the next block.
            nxt_st.in_cnt = '0;
          end
        end
        sde_pkg::SDE_FINISH:
        begin
          // The add cycle folds the block result into the running digest.
          for (int i = 0; i < 5; i++)
          begin
            sum[i] = cur_ff.hash[i] + cur_ff.work[i];
          end
          nxt_st.hash   = sum;
          nxt_st.work   = sum;
          nxt_st.round  = '0;
          if (cur_ff.pad_done)
          begin
            nxt_st.len_room = 1'b1;
          end
          if (cur_ff.len_done)
          begin
            nxt_st.phase  = sde_pkg::SDE_IDLE;
            nxt_st.digest = sum;
            nxt_st.valid  = 1'b1;
          end
          else if (cur_ff.msg_done)
          begin
            nxt_st.phase = sde_pkg::SDE_PAD;
          end
          else
          begin
            nxt_st.phase = sde_pkg::SDE_LOAD;
          end
        end
        sde_pkg::SDE_IDLE:
        begin
          // The digest and its valid flag stay put until the next start.
          nxt_st.phase = sde_pkg::SDE_IDLE;
        end
        default:
        begin
          nxt_st.phase = sde_pkg::SDE_IDLE;
        end
      endcase
    end
    // Request reopens in the add cycle, and the buffer keeps a word taken
    // then until loading resumes; so the block gap stays at 65 cycles in
    // spite of the buffer's stage. It stops once a block's words or the
    // final word are taken.
    nxt_st.req = ((nxt_st.phase == sde_pkg::SDE_LOAD)
                  || (nxt_st.phase == sde_pkg::SDE_FINISH))
                 && (nxt_st.in_cnt < sde_pkg::REQ_WORDS)
                 && !nxt_st.in_last;
    if (!enable)
    begin
      // Enable low holds every field, the request included.
      nxt_st.req = cur_ff.req;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff       <= '0;
      cur_ff.phase <= sde_pkg::SDE_IDLE;
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  assign word_request       = cur_ff.req;
  assign digest_valid       = cur_ff.valid;
  assign digest_word_first  = cur_ff.digest[4];
  assign digest_word_second = cur_ff.digest[3];
  assign digest_word_third  = cur_ff.digest[2];
  assign digest_word_fourth = cur_ff.digest[1];
  assign digest_word_fifth  = cur_ff.digest[0];

endmodule // sde_sha1_engine

// ===== sde_sha1_engine_properties.sv
// Port-level assertions for the message digest engine.
`timescale 1ns/1ps

module sde_sha1_engine_properties (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        enable,
  input wire logic        msg_start,
  input wire logic [31:0] din,
  input wire logic        word_accept,
  input wire logic [1:0]  last_bytes,
  input wire logic        last_word,
  input wire logic        word_request,
  input wire logic        digest_valid,
  input wire logic [31:0] digest_word_first,
  input wire logic [31:0] digest_word_second,
  input wire logic [31:0] digest_word_third,
  input wire logic [31:0] digest_word_fourth,
  input wire logic [31:0] digest_word_fifth
);
  logic [6:0]   low_cnt_ff;
  logic [6:0]   nxt_low_cnt;
  logic [159:0] dig;

  assign dig = {digest_word_first, digest_word_second, digest_word_third,
                digest_word_fourth, digest_word_fifth};

  // Counts enabled cycles with the request low; frozen cycles do not count.
  always_comb
  begin
    nxt_low_cnt = low_cnt_ff;
    if (msg_start || word_request)
      nxt_low_cnt = 7'h00;
    else if (enable && low_cnt_ff != 7'h7F)
      nxt_low_cnt = low_cnt_ff + 7'h01;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      low_cnt_ff <= 7'h00;
    else
      low_cnt_ff <= nxt_low_cnt;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  a_reset_clears: assert property (disable iff (1'b0)
    !nrst |-> !word_request && !digest_valid && dig == 160'h0)
    else $error("outputs not cleared during reset");
  a_stall_holds: assert property (
    enable && word_request && !word_accept && !msg_start |=> word_request)
    else $error("request dropped without a word");
  a_last_drops: assert property (
    enable && word_request && word_accept && last_word && !msg_start
    |=> !word_request)
    else $error("request kept after final word");
  a_block_gap: assert property (
    $rose(word_request) && !$past(msg_start) |-> low_cnt_ff == 7'h41)
    else $error("block compute gap wrong");
  a_start_requests: assert property (
    enable && msg_start |=> word_request && !digest_valid)
    else $error("start did not open a message");
  a_valid_holds: assert property (
    digest_valid && !(msg_start && enable) |=> digest_valid && $stable(dig))
    else $error("digest not held");
  a_freeze_hold: assert property (
    !enable |=> $stable(word_request) && $stable(digest_valid)
    && $stable(dig))
    else $error("outputs moved while disabled");
  a_valid_gap: assert property (
    $rose(digest_valid) |-> !word_request && low_cnt_ff >= 7'h45)
    else $error("digest valid too early");

  c_digest: cover property ($rose(digest_valid));
  c_stall: cover property (word_request && !word_accept ##1 word_accept);
  c_freeze: cover property (!enable && !word_request);
endmodule // sde_sha1_engine_properties

bind sde_sha1_engine sde_sha1_engine_properties u_props (
  .clock(clock), .nrst(nrst), .enable(enable), .msg_start(msg_start),
  .din(din), .word_accept(word_accept), .last_bytes(last_bytes),
  .last_word(last_word), .word_request(word_request),
  .digest_valid(digest_valid), .digest_word_first(digest_word_first),
  .digest_word_second(digest_word_second),
  .digest_word_third(digest_word_third),
  .digest_word_fourth(digest_word_fourth),
  .digest_word_fifth(digest_word_fifth));

// ===== sde_host_model.sv
// Behavioural host that offers message words to the engine.
`timescale 1ns/1ps

module sde_host_model (
  input  wire logic  clock,
  input  wire logic  enable,
  input  wire logic  word_request,
  output logic [31:0] din,
  output logic        word_accept,
  output logic [1:0]  last_bytes,
  output logic        last_word
);
  initial
  begin
    din = 32'h0;
    word_accept = 1'b0;
    last_bytes = 2'h0;
    last_word = 1'b0;
  end

  // An offer is held until a request is seen with enable high; a released
  // word is inverted so a stale value can never be taken for a fresh one.
  task automatic send(input logic [31:0][31:0] w, input int n,
                      input logic [1:0] nb, input int stall, input logic fin);
    for (int i = 0; i < n; i++)
    begin
      din <= w[i];
      last_word <= fin && (i == n - 1);
      last_bytes <= nb;
      word_accept <= 1'b1;
      do
        @(posedge clock);
      while (!(word_request === 1'b1 && enable === 1'b1));
      if (stall > 0 || i == n - 1)
      begin
        word_accept <= 1'b0;
        din <= ~w[i];
        last_word <= 1'b0;
        last_bytes <= ~nb;
        repeat (stall) @(posedge clock);
      end
    end
  endtask
endmodule // sde_host_model

// ===== tb_top.sv
// Self-checking bench of the message digest engine.
`timescale 1ns/1ps

module tb_top;
  logic              clock;
  logic              nrst;
  logic              enable;
  logic              msg_start;
  logic [31:0]       din;
  logic              word_accept;
  logic [1:0]        last_bytes;
  logic              last_word;
  logic              word_request;
  logic              digest_valid;
  logic [4:0][31:0]  dg;
  int                failures;
  int                n_checks;
  int                cycles;

  always #5 clock = ~clock;

  sde_sha1_engine DUT (.clock(clock), .nrst(nrst), .enable(enable),
    .msg_start(msg_start), .din(din), .word_accept(word_accept),
    .last_bytes(last_bytes), .last_word(last_word),
    .word_request(word_request), .digest_valid(digest_valid),
    .digest_word_first(dg[4]), .digest_word_second(dg[3]),
    .digest_word_third(dg[2]), .digest_word_fourth(dg[1]),
    .digest_word_fifth(dg[0]));

  sde_host_model host (.clock(clock), .enable(enable),
    .word_request(word_request), .din(din), .word_accept(word_accept),
    .last_bytes(last_bytes), .last_word(last_word));

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Starts a message, optionally freezes the engine, then waits for the
  // digest under a bounded count.
  task automatic run_msg(input logic [31:0][31:0] w, input int n,
    input logic [1:0] nb, input int stall, input int pause,
    input logic [159:0] exp);
    int k;
    msg_start <= 1'b1;
    @(posedge clock);
    msg_start <= 1'b0;
    host.send(w, n, nb, stall, 1'b1);
    if (pause > 0)
    begin
      enable <= 1'b0;
      repeat (pause) @(posedge clock);
      enable <= 1'b1;
    end
    k = 0;
    while (digest_valid !== 1'b1 && k < 400)
    begin
      @(posedge clock);
      k++;
    end
    check(dg === exp, "digest value");
  endtask

  // Junk below the valid bytes must be masked by the byte count.
  task automatic sc_byte_codes;
    logic [31:0][31:0] w;
    logic [3:0][31:0] wd = {32'h61626364, 32'h616263A5, 32'h6162A5A5,
                            32'h61A5A5A5};
    logic [3:0][159:0] ex = {
      160'h81FE8BFE87576C3ECB22426F8E57847382917ACF,
      160'hA9993E364706816ABA3E25717850C26C9CD0D89D,
      160'hDA23614E02469A0D7C7BD1BDAB5C9C474B1904DC,
      160'h86F7E437FAA5A7FCE15D1DDCB9EAEAEA377667B8};
    for (int nb = 0; nb < 4; nb++)
    begin
      w[0] = wd[nb];
      run_msg(w, 1, nb[1:0], nb, 0, ex[nb]);
    end
    repeat (5) @(posedge clock);
    check(digest_valid === 1'b1 && dg === ex[3], "digest held");
  endtask

  // A 56-byte message forces an extra pad block; 112 bytes spans blocks.
  task automatic sc_long_msgs;
    logic [31:0][31:0] w;
    logic [7:0] c;
    for (int i = 0; i < 14; i++)
    begin
      c = 8'h61 + i[7:0];
      w[i] = {c, c + 8'h01, c + 8'h02, c + 8'h03};
    end
    run_msg(w, 14, 2'h3, 0, 30,
      160'h84983E441C3BD26EBAAE4AA1F95129E5E54670F1);
    for (int i = 0; i < 28; i++)
    begin
      c = 8'h61 + i[8:1] + (i[0] ? 8'h04 : 8'h00);
      w[i] = {c, c + 8'h01, c + 8'h02, c + 8'h03};
    end
    run_msg(w, 28, 2'h3, 0, 0,
      160'hA49B2446A02C645BF419F995B67091253A04A259);
  endtask

  // A fresh start abandons a half-sent block.
  task automatic sc_restart;
    logic [31:0][31:0] w;
    w = '1;
    msg_start <= 1'b1;
    @(posedge clock);
    msg_start <= 1'b0;
    host.send(w, 5, 2'h3, 1, 1'b0);
    check(digest_valid === 1'b0 && word_request === 1'b1, "restart");
    w[0] = 32'h616263A5;
    run_msg(w, 1, 2'h2, 0, 0,
      160'hA9993E364706816ABA3E25717850C26C9CD0D89D);
  endtask

  // Reset lands in mid-computation and must clear outputs at once.
  task automatic sc_mid_reset;
    logic [31:0][31:0] w;
    w[0] = 32'h61A5A5A5;
    msg_start <= 1'b1;
    @(posedge clock);
    msg_start <= 1'b0;
    host.send(w, 1, 2'h0, 0, 1'b1);
    repeat (40) @(posedge clock);
    nrst <= 1'b0;
    @(negedge clock);
    check(dg === '0 && digest_valid === 1'b0, "reset clear");
    @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    run_msg(w, 1, 2'h0, 0, 0,
      160'h86F7E437FAA5A7FCE15D1DDCB9EAEAEA377667B8);
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    enable = 1'b1;
    msg_start = 1'b0;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    check(dg === '0 && word_request === 1'b0, "reset state");
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    sc_byte_codes();
    sc_long_msgs();
    sc_restart();
    sc_mid_reset();
    close_out();
  end
endmodule // tb_top
